//--- cable_detect_pkg.sv
package cable_detect_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ        = 40;
  localparam int HOLD_LOW_US    = 30;  // least discharge time
  localparam int SAMPLE_MIN_US  = 2;   // earliest sample after release
  localparam int SAMPLE_MAX_US  = 13;  // latest sample after release
  localparam int HOLD_LOW_CYC   = HOLD_LOW_US * CLK_MHZ;
  localparam int SAMPLE_MIN_CYC = SAMPLE_MIN_US * CLK_MHZ;
  localparam int SAMPLE_MAX_CYC = SAMPLE_MAX_US * CLK_MHZ;
  // sample in the middle of the window for margin on both sides
  localparam int SAMPLE_AT_CYC  = (SAMPLE_MIN_CYC + SAMPLE_MAX_CYC) / 2;
  // ------------------------------------------------------------
  // identify data field
  // ------------------------------------------------------------
  localparam int     ID_WORD_CABLE = 93;
  localparam int     ID_BIT_CABLE  = 13;
  localparam logic   CABLE_RST     = 1'b0;  // 40-conductor until tested

  typedef enum logic [1:0] {IDLE, DISCHARGE, SETTLE, DONE} det_state_t;
endpackage : cable_detect_pkg

//--- pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // raw pin and settled level
  input  wire logic pinIn,
  output logic      level
);
  logic s1_q, s2_q, s3_q;

  // three stages; the first is read by the second only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level changes only once the two later stages agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b1;
    end else if (s2_q == s3_q) begin
      level <= s3_q;
    end
  end
endmodule : pin_sync
`default_nettype wire

//--- cable_type_detect.sv
// How it works
// - after identify command, drive cable detect line low to discharge
// - then release line and sample before the capacitor recharges
// - low sample means 40-conductor, high sample means 80-conductor
// - report the outcome in the identify data for that command
// - hold line low at least 30 us before identify data moves
// - sample between 2 and 13 us after releasing the line
// - result sits in bit 13 of identify word 93
`timescale 1ns/1ps
`default_nettype none
module cable_type_detect #(
  parameter int HOLD_CYC   = cable_detect_pkg::HOLD_LOW_CYC,
  parameter int SAMPLE_CYC = cable_detect_pkg::SAMPLE_AT_CYC
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // command side
  input  wire logic identifyStart,   // one-cycle pulse, command accepted
  output logic      dataReady,       // identify data may now be sent
  output logic      busy,
  // identify data field
  output logic      cable80,         // word 93 bit 13
  // diag_cable_detect_line, open drain
  input  wire logic cableLineIn,
  output logic      cableLineOut,
  output logic      cableLineOe
);
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  localparam int CW       = 16;
  localparam int SYNC_LAT = 4;  // cycles from pin to lineLevel
  // the counter must hold each span, and the sample must follow release
  if (HOLD_CYC < 1 || HOLD_CYC >= (1 << CW)) begin : g_bad_hold
    $error("HOLD_CYC out of range");
  end
  if (SAMPLE_CYC <= SYNC_LAT || SAMPLE_CYC >= (1 << CW)) begin : g_bad_samp
    $error("SAMPLE_CYC out of range");
  end

  localparam logic [CW-1:0] HOLD_LAST   = CW'(HOLD_CYC - 1);
  localparam logic [CW-1:0] SAMPLE_LAST = CW'(SAMPLE_CYC - 1);

  // ------------------------------------------------------------
  // pin input
  // ------------------------------------------------------------
  logic lineLevel;
  pin_sync u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pinIn (cableLineIn),
    .level (lineLevel)
  );

  cable_detect_pkg::det_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic          cntDone;

  always_comb begin
    cntDone = 1'b0;
    case (state_q)
      cable_detect_pkg::DISCHARGE: cntDone = (cnt_q == HOLD_LAST);
      cable_detect_pkg::SETTLE:    cntDone = (cnt_q == SAMPLE_LAST);
      default:                     cntDone = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  // a new identify restarts the test even mid-sequence
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= cable_detect_pkg::IDLE;
    end else if (identifyStart) begin
      state_q <= cable_detect_pkg::DISCHARGE;
    end else begin
      case (state_q)
        cable_detect_pkg::DISCHARGE:
          if (cntDone) state_q <= cable_detect_pkg::SETTLE;
        cable_detect_pkg::SETTLE:
          if (cntDone) state_q <= cable_detect_pkg::DONE;
        cable_detect_pkg::DONE:
          state_q <= cable_detect_pkg::IDLE;
        default:
          state_q <= state_q;
      endcase
    end
  end

  // one counter serves both timed phases
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (identifyStart || cntDone) begin
      cnt_q <= '0;
    end else if (state_q == cable_detect_pkg::DISCHARGE ||
                 state_q == cable_detect_pkg::SETTLE) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // ------------------------------------------------------------
  // pin drive and result
  // ------------------------------------------------------------
  // the line is only ever pulled low; high comes from pull-ups
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cableLineOe  <= 1'b0;
      cableLineOut <= 1'b0;
    end else begin
      cableLineOut <= 1'b0;
      cableLineOe  <= identifyStart ||
        (state_q == cable_detect_pkg::DISCHARGE && !cntDone);
    end
  end

  // lineLevel is SYNC_LAT cycles old, so SAMPLE_CYC must allow for it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cable80 <= cable_detect_pkg::CABLE_RST;
    end else if (state_q == cable_detect_pkg::SETTLE && cntDone) begin
      cable80 <= lineLevel;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dataReady <= 1'b0;
      busy      <= 1'b0;
    end else begin
      dataReady <= (state_q == cable_detect_pkg::DONE) &&
                   !identifyStart;
      busy      <= identifyStart ||
                   (state_q == cable_detect_pkg::DISCHARGE) ||
                   (state_q == cable_detect_pkg::SETTLE && !cntDone);
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_start;
    identifyStart ##1 cableLineOe;
  endsequence

  a_drive_low_start: assert property (
    @(posedge mclk) disable iff (!rst_n)
    identifyStart |=> cableLineOe && !cableLineOut)
    else $error("line not driven low after identify");

  a_hold_low_time: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(cableLineOe) |-> cableLineOe[*8])
    else $error("discharge pulse too short");

  a_never_drive_hi: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cableLineOe |-> !cableLineOut)
    else $error("line driven high");

  a_ready_after_release: assert property (
    @(posedge mclk) disable iff (!rst_n)
    dataReady |-> !cableLineOe && !$past(cableLineOe))
    else $error("data ready while discharging");

  a_sample_takes_level: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (state_q == cable_detect_pkg::SETTLE && cntDone && !identifyStart)
      |=> cable80 == $past(lineLevel))
    else $error("result does not follow sampled level");

  a_result_stable: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !(state_q == cable_detect_pkg::SETTLE && cntDone)
      |=> $stable(cable80))
    else $error("result changed outside sample point");

  a_release_window: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $fell(cableLineOe) && !identifyStart |-> !cableLineOe[*2])
    else $error("line re-driven during sample window");

  a_start_seq: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_start |-> busy)
    else $error("busy not raised during test");

  // ------------------------------------------------------------
  // guard counters
  // ------------------------------------------------------------
  // length of the current drive-low pulse and of the current release;
  // both saturate so a long idle or a string of restarts cannot wrap
  logic [CW-1:0] lowLen_q;
  logic [CW-1:0] relLen_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lowLen_q <= '0;
    end else if (!cableLineOe) begin
      lowLen_q <= '0;
    end else if (lowLen_q != '1) begin
      lowLen_q <= lowLen_q + CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      relLen_q <= '0;
    end else if (cableLineOe) begin
      relLen_q <= '0;
    end else if (relLen_q != '1) begin
      relLen_q <= relLen_q + CW'(1);
    end
  end

  // the sample point of an undisturbed test, then the cycle after it
  sequence s_sample_point;
    state_q == cable_detect_pkg::SETTLE && cntDone && !identifyStart;
  endsequence

  sequence s_sample_then_go;
    s_sample_point ##1 !identifyStart;
  endsequence

  a_hold_full_len: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $fell(cableLineOe) |-> lowLen_q > HOLD_LAST)
    else $error("discharge pulse shorter than hold time");

  a_sample_gap: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_sample_point |-> relLen_q == SAMPLE_LAST)
    else $error("sample not taken at end of release gap");

  a_ready_follows: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_sample_then_go |=> dataReady)
    else $error("no data ready after sample");

  a_ready_single: assert property (
    @(posedge mclk) disable iff (!rst_n)
    dataReady |=> !dataReady)
    else $error("data ready longer than one cycle");
endmodule : cable_type_detect
`default_nettype wire

//--- cable_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module cable_line_model #(
  parameter int RISE_CYC = 8
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // device side of the open-drain line
  input  wire logic cableLineOe,
  input  wire logic cableLineOut,
  output logic      cableLineIn,
  // host capacitor seen through a 40-conductor cable
  input  wire logic capFitted,
  // identify result as the host reads it, and the host's mode choice
  input  wire logic dataReady,
  input  wire logic cable80,
  output logic      fastModes
);
  int relCnt_q;
  // cycles since release; a short rise keeps late samples honest
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) relCnt_q <= RISE_CYC;
    else if (cableLineOe) relCnt_q <= 0;
    else if (relCnt_q < RISE_CYC) relCnt_q <= relCnt_q + 1;
  end
  // lone device: nothing else holds the line low
  // no capacitor: the pull-up wins at once
  assign cableLineIn = (cableLineOe && !cableLineOut) ? 1'b0 :
                       (capFitted ? (relCnt_q >= RISE_CYC) : 1'b1);
  // host allows ultra dma above mode 2 only on a reported 80-conductor
  // cable and uses that cap when it sets the mode it trusts
  // the device here, the less favoured way, own sensing not modelled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) fastModes <= 1'b0;
    else if (dataReady) fastModes <= cable80;
  end
endmodule : cable_line_model
`default_nettype wire

//--- cable_type_detect_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cable_type_detect_tb_top;
  localparam int HOLD = 10;
  localparam int SAMP = 6;
  logic mclk          = 1'b0;
  logic rst_n         = 1'b0;
  logic identifyStart = 1'b0;
  logic capFitted     = 1'b0;
  logic dataReady, busy, cable80, cableLineIn, cableLineOut, cableLineOe;
  logic fastModes;
  logic c;
  logic expQ[$];
  int   errors    = 0;
  int   cmp_count = 0;
  int   cycles    = 0;

  always #12.5 mclk = ~mclk;

  cable_type_detect #(.HOLD_CYC(HOLD), .SAMPLE_CYC(SAMP)) cable_type_detect_i (
    .mclk, .rst_n, .identifyStart, .dataReady, .busy, .cable80,
    .cableLineIn, .cableLineOut, .cableLineOe);
  cable_line_model #(.RISE_CYC(SAMP + 2)) cable_line_model_i (
    .mclk, .rst_n, .cableLineOe, .cableLineOut, .cableLineIn, .capFitted,
    .dataReady, .cable80, .fastModes);

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  // one identify: count cycles to the answer and the discharge length
  task automatic run(input logic cap);
    int n;
    int oeCnt;
    int busyCnt;
    n = 0;
    oeCnt = 0;
    busyCnt = 0;
    capFitted = cap;
    expQ.push_back(!cap);
    identifyStart = 1'b1;
    @(negedge mclk);
    identifyStart = 1'b0;
    // counted from the first cycle after the take edge
    while (dataReady !== 1'b1 && n < 100) begin
      if (cableLineOe === 1'b1) oeCnt++;
      if (busy === 1'b1) busyCnt++;
      @(negedge mclk);
      n++;
    end
    chk(16'(n), 16'(HOLD + SAMP + 1));
    chk(16'(oeCnt), 16'(HOLD));
    chk(16'(busyCnt), 16'(HOLD + SAMP));
    chk(16'(busy), 16'(0));
    chk(16'(cableLineOut), 16'(0));
    chk(16'(cable80), 16'(expQ.pop_front()));
    @(negedge mclk);
    chk(16'(dataReady), 16'(0));
    chk(16'(fastModes), 16'(!cap));
  endtask : run

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(92745));
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    // random cable types, result held across idle gaps
    for (int i = 0; i < 8; i++) begin
      c = 1'($urandom_range(1, 0));
      run(c);
      repeat ($urandom_range(6, 1)) @(negedge mclk);
      chk(16'(cable80), 16'(!c));
      $display("test %0d done, capacitor %0d", i, c);
    end
    // restart mid-test: only the second command answers
    identifyStart = 1'b1;
    @(negedge mclk);
    identifyStart = 1'b0;
    repeat ($urandom_range(HOLD + 2, 1)) @(negedge mclk);
    run(1'b1);
    $display("restart test done");
    // reset mid-discharge drops the line and the result
    run(1'b0);
    identifyStart = 1'b1;
    @(negedge mclk);
    identifyStart = 1'b0;
    repeat (5) @(negedge mclk);
    rst_n = 1'b0;
    @(negedge mclk);
    chk(16'(cableLineOe), 16'(0));
    chk(16'(cable80), 16'(cable_detect_pkg::CABLE_RST));
    chk(16'(busy), 16'(0));
    rst_n = 1'b1;
    run(1'b0);
    $display("reset test done");
    end_of_test();
  end
endmodule : cable_type_detect_tb_top
`default_nettype wire
